/* core/fsc_top.sv */
// Security gate, backdoor key check and program/erase clock ratio of the flash controller.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns

// Function
// - Insecure-source access to flash or RAM while secure: writes dropped, reads zero.
// - Flash and RAM are secure; registers and debug stay open; secure code unrestricted.
// - Only security code 1:0 is unsecured; the other three codes are secure.
// - Each reset copies the nonvolatile option byte into the working option register.
// - Erased option byte reads 1:1, so the part leaves reset secure.
// - Debug module stays disabled while secure; debug still reaches unsecured resources.
// - Backdoor permit bit 7 at 0 disables the key; only full erase unlocks then.
// - Key writes while key entry is selected are compared, never start commands.
// - Clearing key entry with a matching key sets code 1:0 until reset.
// - Only secure code may enter key bytes; debug key writes never count.
// - Protection register is written only by debug; software writes are ignored.
// - Blank check finding flash erased unlocks the part until the next reset.
// - Ratio bit 7 read-only; bits 6:0 take only the first write after reset.
// - Loaded flag set by first ratio write; program and erase need it set.
// - Prescale bit 6 selects bus clock or bus clock divided by eight.
// - Selected input divided by ratio bits 5:0 plus one gives program/erase clock.
// - Each timing pulse lasts one bus clock cycle and comes once per program/erase clock period.
// - Unlocking changes only working copies, never nonvolatile protection, security or key.
// - Flash write before ratio is loaded sets access error and starts nothing.
// - With key entry clear, key range writes start a program or erase command.
// - The unlocking blank check is command code 0x05.
module fsc_top
  import fsc_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Bus access
  input  wire logic [15:0] ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  input  wire logic        DBG_I,
  input  wire logic        SECURE_FETCH_I,
  output logic      [7:0]  RDATA_O,
  // Memory array side
  input  wire logic [7:0]  MEM_RDATA_I,
  output logic             MEM_WE_O,
  output logic             CMD_START_O,
  output logic      [15:0] WADDR_O,
  output logic      [7:0]  WDATA_O,
  // Nonvolatile copies
  input  wire logic [7:0]  NONVOLATILE_OPTION_BYTE_I,
  input  wire logic [7:0]  NVPROT_I,
  input  wire logic [63:0] NVKEY_I,
  // Command sequencer
  input  wire logic        DONE_I,
  input  wire logic [7:0]  DONE_CMD_I,
  input  wire logic        ERASED_I,
  output logic             ACC_ERR_O,
  output logic             PE_EN_O,
  output logic             PE_TICK_O,
  output logic      [7:0]  PROT_O,
  // Security and debug
  input  wire logic        DBG_MOD_REQ_I,
  output logic             DBG_MOD_EN_O,
  output logic             SECURE_O
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  function automatic logic in_flash(input logic [15:0] a);
    in_flash = (a >= FLASH_LO) && (a <= FLASH_HI);
  endfunction : in_flash

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= RAM_LO) && (a <= RAM_HI);
  endfunction : in_ram

  function automatic logic in_key(input logic [15:0] a);
    in_key = (a >= KEY_LO) && (a <= KEY_HI);
  endfunction : in_key

  // Byte 0 of the key vector is the lowest key location.
  function automatic logic [7:0] key_byte(input logic [63:0] k, input logic [2:0] i);
    key_byte = k[{i, 3'h0} +: 8];
  endfunction : key_byte

  fsc_state_t state_r;
  fsc_state_t state_nxt;

  logic insecure_src;
  logic secure_mem;
  logic blocked;
  logic key_hit;
  logic run_wr;
  logic flash_wr;
  logic err_set;
  logic err_clr;
  logic blank_ok;
  logic key_close;

  assign insecure_src = DBG_I | ~SECURE_FETCH_I;
  assign secure_mem   = in_flash(ADDR_I) | in_ram(ADDR_I);
  assign blocked      = state_r.secure & insecure_src & secure_mem;
  assign key_hit      = in_key(ADDR_I) & state_r.key_sel;
  assign run_wr       = WR_I & (state_r.st == PH_RUN);
  assign flash_wr     = run_wr & in_flash(ADDR_I) & ~blocked & ~key_hit;
  assign err_set      = flash_wr & ~state_r.loaded;
  assign err_clr      = run_wr & (ADDR_I == A_STAT) & WDATA_I[STAT_ERR_BIT];
  assign blank_ok     = DONE_I & (DONE_CMD_I == CMD_BLANK) & ERASED_I;
  assign key_close    = run_wr & (ADDR_I == A_CFG) & state_r.key_sel
                        & ~WDATA_I[CFG_KEYSEL_BIT];

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_nxt           = state_r;
    state_nxt.rdata     = 8'h00;
    state_nxt.cmd_start = 1'b0;
    state_nxt.mem_we    = 1'b0;
    state_nxt.tick      = 1'b0;
    unique case (state_r.st)
      PH_LOAD: begin
        // Option, protection and key are taken one cycle after reset release,
        // which keeps the asynchronous reset path free of port values.
        state_nxt.opt  = NONVOLATILE_OPTION_BYTE_I;
        state_nxt.prot = NVPROT_I;
        state_nxt.key  = NVKEY_I;
        state_nxt.st   = PH_RUN;
      end
      PH_RUN: begin
        if (RD_I) begin
          if (secure_mem) begin
            state_nxt.rdata = blocked ? 8'h00 : MEM_RDATA_I;
          end else begin
            case (ADDR_I)
              A_RATIO: state_nxt.rdata = {state_r.loaded, state_r.ratio};
              A_CFG:   state_nxt.rdata = {2'b00, state_r.key_sel, 5'b00000};
              A_OPT:   state_nxt.rdata = state_r.opt;
              A_PROT:  state_nxt.rdata = state_r.prot;
              A_STAT:  state_nxt.rdata = {3'b000, state_r.acc_err, 3'b000, state_r.secure};
              default: state_nxt.rdata = 8'h00;
            endcase
          end
        end
        if (WR_I) begin
          if (ADDR_I == A_RATIO) begin
            if (!state_r.loaded) begin
              state_nxt.ratio  = WDATA_I[6:0];
              state_nxt.loaded = 1'b1;
            end
          end
          if (ADDR_I == A_CFG) begin
            state_nxt.key_sel = WDATA_I[CFG_KEYSEL_BIT];
            // Only the working code changes; the nonvolatile copy stays intact.
            if (key_close && state_r.key_cnt == KEY_CNT_FULL && state_r.key_ok
                && state_r.opt[OPT_PERMIT_BIT]) begin
              state_nxt.opt[1:0] = SEC_OPEN;
            end
            if (state_r.key_sel != WDATA_I[CFG_KEYSEL_BIT]) begin
              state_nxt.key_cnt = 4'h0;
              state_nxt.key_ok  = 1'b1;
            end
          end
          if (ADDR_I == A_PROT && DBG_I) begin
            state_nxt.prot = WDATA_I;
          end
          if (in_flash(ADDR_I) && !blocked) begin
            if (key_hit) begin
              // Key writes are compared only; a debug write is dropped here.
              if (!insecure_src) begin
                if (state_r.key_cnt == {1'b0, ADDR_I[2:0]}) begin
                  state_nxt.key_ok  = state_r.key_ok
                                      & (WDATA_I == key_byte(state_r.key, ADDR_I[2:0]));
                  state_nxt.key_cnt = state_r.key_cnt + 4'h1;
                end else begin
                  state_nxt.key_ok = 1'b0;
                end
              end
            end else if (state_r.loaded) begin
              state_nxt.cmd_start = 1'b1;
              state_nxt.waddr     = ADDR_I;
              state_nxt.wdata     = WDATA_I;
            end
          end
          if (in_ram(ADDR_I) && !blocked) begin
            state_nxt.mem_we = 1'b1;
            state_nxt.waddr  = ADDR_I;
            state_nxt.wdata  = WDATA_I;
          end
        end
        if (blank_ok) begin
          state_nxt.opt[1:0] = SEC_OPEN;
        end
        // An error raised in the cycle of its clear survives the clear.
        state_nxt.acc_err = (state_r.acc_err & ~err_clr) | err_set;
        if (state_r.loaded) begin
          state_nxt.pre = state_r.pre + 3'h1;
          if (!state_r.ratio[RATIO_PRESCALE_BIT] || state_r.pre == PRE_LAST) begin
            if (state_r.div == state_r.ratio[5:0]) begin
              state_nxt.div  = 6'h00;
              state_nxt.tick = 1'b1;
            end else begin
              state_nxt.div = state_r.div + 6'h01;
            end
          end
        end
      end
    endcase
    state_nxt.secure = state_nxt.opt[1:0] != SEC_OPEN;
    state_nxt.dbg_en = DBG_MOD_REQ_I & ~state_nxt.secure;
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= FSC_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign RDATA_O      = state_r.rdata;
  assign MEM_WE_O     = state_r.mem_we;
  assign CMD_START_O  = state_r.cmd_start;
  assign WADDR_O      = state_r.waddr;
  assign WDATA_O      = state_r.wdata;
  assign ACC_ERR_O    = state_r.acc_err;
  assign PE_EN_O      = state_r.loaded;
  assign PE_TICK_O    = state_r.tick;
  assign PROT_O       = state_r.prot;
  assign DBG_MOD_EN_O = state_r.dbg_en;
  assign SECURE_O     = state_r.secure;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence key_close_s;
    key_close && !blank_ok;
  endsequence

  sequence key_good_s;
    state_r.key_cnt == KEY_CNT_FULL && state_r.key_ok && state_r.opt[OPT_PERMIT_BIT];
  endsequence

  read_zero_a:
    assert property (state_r.st == PH_RUN && RD_I && blocked |=> RDATA_O == 8'h00)
    else $error("blocked read returned data");

  write_drop_a:
    assert property (WR_I && blocked |=> !CMD_START_O && !MEM_WE_O)
    else $error("blocked write passed to memory");

  reset_code_a:
    assert property (state_r.st == PH_LOAD |=> SECURE_O ==
                     ($past(NONVOLATILE_OPTION_BYTE_I[1:0]) != SEC_OPEN))
    else $error("security after load does not follow option code");

  load_copy_a:
    assert property (state_r.st == PH_LOAD |=> state_r.opt == $past(NONVOLATILE_OPTION_BYTE_I)
                     && PROT_O == $past(NVPROT_I))
    else $error("option or protection not copied at reset");

  dbg_gate_a:
    assert property (SECURE_O |-> !DBG_MOD_EN_O)
    else $error("debug module enabled while secure");

  key_no_cmd_a:
    assert property (state_r.st == PH_RUN && WR_I && key_hit |=> !CMD_START_O)
    else $error("key write started a command");

  key_unlock_a:
    assert property (key_close_s ##0 key_good_s |=> !SECURE_O ##1 !SECURE_O)
    else $error("matching key did not unlock");

  key_reject_a:
    assert property (key_close_s ##0 (state_r.key_cnt != KEY_CNT_FULL || !state_r.key_ok)
                     ##0 SECURE_O |=> SECURE_O)
    else $error("incomplete or wrong key unlocked");

  dbg_key_a:
    assert property (run_wr && key_hit && DBG_I |=> $stable(state_r.key_cnt))
    else $error("debug key write counted");

  prot_sw_a:
    assert property (state_r.st == PH_RUN && !(run_wr && ADDR_I == A_PROT && DBG_I)
                     |=> $stable(PROT_O))
    else $error("protection changed without debug write");

  blank_unlock_a:
    assert property (state_r.st == PH_RUN && blank_ok |=> !SECURE_O)
    else $error("blank check did not unlock");

  ratio_once_a:
    assert property (state_r.loaded |=> state_r.loaded && $stable(state_r.ratio))
    else $error("ratio changed after first write");

  loaded_set_a:
    assert property (run_wr && ADDR_I == A_RATIO |=> PE_EN_O)
    else $error("loaded flag not set by ratio write");

  early_err_a:
    assert property (err_set |=> ACC_ERR_O && !CMD_START_O)
    else $error("early flash write not flagged");

  tick_idle_a:
    assert property (!state_r.loaded |-> ##1 !PE_TICK_O)
    else $error("timing pulse before ratio loaded");

endmodule : fsc_top

/* shared/fsc_pkg.sv */
// Constants, types and the register map of the flash security and clock ratio block.
package fsc_pkg;

  // ---------------------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------------------
  localparam logic [15:0] A_RATIO  = 16'h1820;
  localparam logic [15:0] A_CFG    = 16'h1821;
  localparam logic [15:0] A_OPT    = 16'h1822;
  localparam logic [15:0] A_PROT   = 16'h1823;
  localparam logic [15:0] A_STAT   = 16'h1824;
  localparam logic [15:0] RAM_LO   = 16'h0080;
  localparam logic [15:0] RAM_HI   = 16'h047f;
  localparam logic [15:0] FLASH_LO = 16'h8000;
  localparam logic [15:0] FLASH_HI = 16'hffff;
  localparam logic [15:0] KEY_LO   = 16'hffb0;
  localparam logic [15:0] KEY_HI   = 16'hffb7;

  // ---------------------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------------------
  localparam int          CFG_KEYSEL_BIT     = 5;
  localparam int          OPT_PERMIT_BIT     = 7;
  localparam int          RATIO_LOADED_BIT   = 7;
  localparam int          RATIO_PRESCALE_BIT = 6;
  localparam int          STAT_ERR_BIT       = 4;
  localparam int          STAT_SEC_BIT       = 0;
  localparam logic [1:0]  SEC_OPEN           = 2'b10;
  localparam logic [7:0]  CMD_BLANK          = 8'h05;
  localparam logic [3:0]  KEY_CNT_FULL       = 4'h8;
  localparam logic [2:0]  PRE_LAST           = 3'h7;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  OPT_RST  = 8'hff;
  localparam logic [7:0]  PROT_RST = 8'hff;

  // ---------------------------------------------------------------------------
  // Timing of the program/erase clock
  // ---------------------------------------------------------------------------
  localparam int CLK_KHZ      = 125000;
  localparam int FCLK_MAX_KHZ = 200;
  localparam int FCLK_MIN_KHZ = 150;
  localparam int PE_CYC_MIN   = (CLK_KHZ + FCLK_MAX_KHZ - 1) / FCLK_MAX_KHZ;
  localparam int PE_CYC_MAX   = CLK_KHZ / FCLK_MIN_KHZ;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_LOAD = 2'b00,
    PH_RUN  = 2'b01
  } fsc_phase_t;

  typedef struct packed {
    fsc_phase_t  st;
    logic [7:0]  opt;
    logic [7:0]  prot;
    logic [63:0] key;
    logic [6:0]  ratio;
    logic        loaded;
    logic        key_sel;
    logic [3:0]  key_cnt;
    logic        key_ok;
    logic        acc_err;
    logic [2:0]  pre;
    logic [5:0]  div;
    logic        tick;
    logic [7:0]  rdata;
    logic        cmd_start;
    logic        mem_we;
    logic [15:0] waddr;
    logic [7:0]  wdata;
    logic        secure;
    logic        dbg_en;
  } fsc_state_t;

  localparam fsc_state_t FSC_RST = '{st: PH_LOAD, opt: OPT_RST, prot: PROT_RST,
                                     secure: 1'b1, key_ok: 1'b1, default: '0};

endpackage : fsc_pkg

/* testbench/flash_security_and_clock_divider_tb.sv */
// Self-checking bench for the flash security gate and program/erase clock ratio.
`timescale 1ns/1ns
module flash_security_and_clock_divider_tb;
  import fsc_pkg::*;

  logic        CLK_I, MEM_WE_O, CMD_START_O, DONE_I, ERASED_I, ACC_ERR_O, PE_EN_O;
  logic        PE_TICK_O, DBG_MOD_EN_O, SECURE_O;
  logic        RST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0, DBG_I = 1'b0, SECURE_FETCH_I = 1'b0;
  logic        DBG_MOD_REQ_I = 1'b0, go = 1'b0, erased = 1'b0;
  logic [15:0] ADDR_I = '0, WADDR_O;
  logic [7:0]  WDATA_I = '0, NONVOLATILE_OPTION_BYTE_I = 8'hff, NVPROT_I = 8'hfe, cmd = '0;
  logic [7:0]  RDATA_O, MEM_RDATA_I, WDATA_O, DONE_CMD_I, PROT_O, q;
  logic [63:0] NVKEY_I = 64'h8877665544332211;
  int          err_total = 0, check_count = 0, cmd_cnt = 0, i;

  fsc_top DUT (.CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .DBG_I(DBG_I), .SECURE_FETCH_I(SECURE_FETCH_I), .RDATA_O(RDATA_O),
    .MEM_RDATA_I(MEM_RDATA_I), .MEM_WE_O(MEM_WE_O), .CMD_START_O(CMD_START_O),
    .WADDR_O(WADDR_O), .WDATA_O(WDATA_O), .NVPROT_I(NVPROT_I), .NVKEY_I(NVKEY_I),
    .NONVOLATILE_OPTION_BYTE_I(NONVOLATILE_OPTION_BYTE_I), .DONE_I(DONE_I),
    .DONE_CMD_I(DONE_CMD_I), .ERASED_I(ERASED_I),
    .ACC_ERR_O(ACC_ERR_O), .PE_EN_O(PE_EN_O), .PE_TICK_O(PE_TICK_O), .PROT_O(PROT_O),
    .DBG_MOD_REQ_I(DBG_MOD_REQ_I), .DBG_MOD_EN_O(DBG_MOD_EN_O), .SECURE_O(SECURE_O));

  fsc_seq_model seq (.clk_i(CLK_I), .rst_i(RST_I), .addr_i(ADDR_I), .mem_rdata_o(MEM_RDATA_I),
    .go_i(go), .cmd_i(cmd), .erased_i(erased), .done_o(DONE_I), .done_cmd_o(DONE_CMD_I),
    .erased_o(ERASED_I));

  initial begin
    CLK_I = 1'b0;
    forever #4 CLK_I = ~CLK_I;
  end

  // Command pulses are counted so that a stray start shows up at any later check.
  always @(posedge CLK_I) begin
    if (CMD_START_O === 1'b1) cmd_cnt++;
  end

  // ---------------------------------------------------------------------------
  // Bus, compare and report tasks
  // ---------------------------------------------------------------------------
  task automatic chk1(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  // One strobe cycle; returns just after the edge that takes it, read data captured there.
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
                     input logic dbg, input logic sf);
    @(posedge CLK_I);
    WR_I           <= w;
    RD_I           <= !w;
    ADDR_I         <= a;
    WDATA_I        <= d;
    DBG_I          <= dbg;
    SECURE_FETCH_I <= sf;
    @(posedge CLK_I);
    WR_I <= 1'b0;
    RD_I <= 1'b0;
    #1;
    q = RDATA_O;
  endtask : bus

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic dbg, input logic sf);
    bus(1'b1, a, d, dbg, sf);
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic dbg, input logic sf,
                     input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00, dbg, sf);
    chk8(n, e, q);
  endtask : rdc

  task automatic rst(input logic [7:0] opt);
    @(posedge CLK_I);
    RST_I   <= 1'b1;
    NONVOLATILE_OPTION_BYTE_I <= opt;
    repeat (2) @(posedge CLK_I);
    RST_I <= 1'b0;
    @(posedge CLK_I);
    #1;
  endtask : rst

  // Unlock takes effect on the next cycle; three cycles leave room for a late change.
  task automatic sec(input logic e);
    repeat (3) begin
      @(posedge CLK_I);
      #1;
    end
    chk1("secure", e, SECURE_O);
  endtask : sec

  // Key bytes go out ascending with an idle cycle between them, never back to back.
  task automatic key(input int bad, input logic dbg);
    wr(A_CFG, 8'h20, 1'b0, 1'b1);
    rdc(A_CFG, 1'b0, 1'b1, 8'h20, "key select");
    for (int k = 0; k < 8; k++)
      wr(KEY_LO + 16'(k), NVKEY_I[8*k +: 8] ^ ((k == bad) ? 8'hff : 8'h00), dbg, !dbg);
    wr(A_CFG, 8'h00, 1'b0, 1'b1);
  endtask : key

  task automatic tick(input logic [7:0] e);
    int n;
    n = 0;
    while (PE_TICK_O !== 1'b1 && n < 600) begin
      @(posedge CLK_I);
      #1;
      n++;
    end
    if (PE_TICK_O !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    n = 0;
    do begin
      @(posedge CLK_I);
      #1;
      n++;
    end while (PE_TICK_O !== 1'b1 && n < 600);
    if (PE_TICK_O !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
    chk8("tick period", e, 8'(n));
  endtask : tick

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic blank(input logic [7:0] c, input logic e);
    @(posedge CLK_I);
    cmd    <= c;
    erased <= e;
    go     <= 1'b1;
    @(posedge CLK_I);
    go <= 1'b0;
    for (int k = 0; k < 20 && DONE_I !== 1'b1; k++) begin
      @(posedge CLK_I);
      #1;
    end
    if (DONE_I !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
  endtask : blank

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    for (i = 0; i < 4; i++) begin
      rst({6'h3f, i[1:0]});
      chk1("secure", i != 2, SECURE_O);
      rdc(A_OPT, 1'b1, 1'b0, {6'h3f, i[1:0]}, "option");
    end
    chk8("protection", 8'hfe, PROT_O);
    chk1("pe enable", 1'b0, PE_EN_O);
    wr(16'h9000, 8'h55, 1'b0, 1'b1);
    chk1("access error", 1'b1, ACC_ERR_O);
    rdc(A_STAT, 1'b1, 1'b0, 8'h11, "status");
    wr(A_STAT, 8'h10, 1'b0, 1'b1);
    chk1("access error", 1'b0, ACC_ERR_O);
    chk8("commands", 8'h00, 8'(cmd_cnt));
    $display("test reset and unloaded write finished");
    rdc(16'h8123, 1'b0, 1'b0, 8'h00, "flash read");
    rdc(16'h8123, 1'b1, 1'b0, 8'h00, "flash read");
    rdc(16'h8123, 1'b0, 1'b1, 8'h9e, "flash read");
    wr(16'h0100, 8'ha5, 1'b0, 1'b0);
    chk1("ram write", 1'b0, MEM_WE_O);
    wr(16'h0100, 8'ha5, 1'b0, 1'b1);
    chk1("ram write", 1'b1, MEM_WE_O);
    chk8("write data", 8'ha5, WDATA_O);
    chk8("write address", 8'h01, WADDR_O[15:8]);
    wr(A_PROT, 8'h00, 1'b0, 1'b1);
    chk8("protection", 8'hfe, PROT_O);
    wr(A_PROT, 8'h00, 1'b1, 1'b0);
    chk8("protection", 8'h00, PROT_O);
    @(posedge CLK_I);
    DBG_MOD_REQ_I <= 1'b1;
    sec(1'b1);
    chk1("debug module", 1'b0, DBG_MOD_EN_O);
    $display("test blocking finished");
    wr(A_RATIO, 8'h45, 1'b0, 1'b1);
    chk1("pe enable", 1'b1, PE_EN_O);
    wr(A_RATIO, 8'h01, 1'b0, 1'b1);
    rdc(A_RATIO, 1'b0, 1'b1, 8'hc5, "ratio");
    tick(8'h30);
    wr(16'hffb0, 8'h00, 1'b0, 1'b1);
    sec(1'b1);
    chk8("commands", 8'h01, 8'(cmd_cnt));
    chk8("write address", 8'hb0, WADDR_O[7:0]);
    $display("test ratio finished");
    key(-1, 1'b1);
    sec(1'b1);
    key(7, 1'b0);
    sec(1'b1);
    key(-1, 1'b0);
    sec(1'b0);
    chk8("commands", 8'h01, 8'(cmd_cnt));
    chk1("debug module", 1'b1, DBG_MOD_EN_O);
    rdc(16'h8123, 1'b1, 1'b0, 8'h9e, "flash read");
    $display("test backdoor key finished");
    rst(8'h7f);
    wr(A_RATIO, 8'h05, 1'b0, 1'b1);
    tick(8'h06);
    key(-1, 1'b0);
    sec(1'b1);
    blank(8'h41, 1'b1);
    sec(1'b1);
    blank(CMD_BLANK, 1'b0);
    sec(1'b1);
    blank(CMD_BLANK, 1'b1);
    sec(1'b0);
    $display("test debug unlock finished");
    report_and_stop();
  end
endmodule : flash_security_and_clock_divider_tb

/* testbench/fsc_seq_model.sv */
// Behavioural model of the flash array and command sequencer beside the security block.
`timescale 1ns/1ns
module fsc_seq_model #(
  parameter int LAT = 5
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Array read port
  input  wire logic [15:0] addr_i,
  output logic      [7:0]  mem_rdata_o,
  // Command requests from the bench
  input  wire logic        go_i,
  input  wire logic [7:0]  cmd_i,
  input  wire logic        erased_i,
  output logic             done_o,
  output logic      [7:0]  done_cmd_o,
  output logic             erased_o
);
  int cnt_r;

  // Array data is an address hash; a blocked read of zero matches by chance only where the address bytes XOR to 0x3c.
  assign mem_rdata_o = addr_i[7:0] ^ addr_i[15:8] ^ 8'h3c;
  // Outside the done pulse the result lines carry inverted values, never stale ones.
  assign done_cmd_o  = done_o ? cmd_i : ~cmd_i;
  assign erased_o    = done_o ? erased_i : ~erased_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= 0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_r == 1);
      if (go_i) begin
        cnt_r <= LAT;
      end else if (cnt_r != 0) begin
        cnt_r <= cnt_r - 1;
      end
    end
  end
endmodule : fsc_seq_model
